// file: logic/pps_pkg.sv
// Constants for the pair source selector of the six-output PWM unit.
// Assumes every user shares one clock and imports nothing: names are scoped.
package pps_pkg;

  // Output and pair counts
  localparam int unsigned CHANNELS  = 6;
  localparam int unsigned PAIRS     = 3;
  localparam int unsigned SEL_WIDTH = 2;

  // Source select encodings for one pair
  localparam logic [1:0] SEL_GPIO  = 2'h0;
  localparam logic [1:0] SEL_TIMER = 2'h1;
  localparam logic [1:0] SEL_ADC   = 2'h2;
  localparam logic [1:0] SEL_GEN   = 2'h3;

  // Reset values
  localparam logic [5:0] PWM_RST       = 6'h00;
  localparam logic [2:0] ADC_LEVEL_RST = 3'h0;
  localparam logic [2:0] ALT_RST       = 3'h0;
  localparam logic       SYNC_RST      = 1'b0;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

endpackage : pps_pkg

// file: logic/pps_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to sys_clk; only stage two is read outside.
`timescale 1ns/10ps
`default_nettype none

module pps_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next values: stage one feeds stage two only
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= {WIDTH{pps_pkg::SYNC_RST}};
      sync_q <= {WIDTH{pps_pkg::SYNC_RST}};
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pps_sync

`default_nettype wire

// file: logic/pps_top.sv
// Pair source selector sitting between the PWM generator and the output stage.
// Assumes generator, timer, ADC limit and control inputs share sys_clk;
// the port B lines are pins and are synchronised here.
//
// Overview of operation
// - Alternate source only when both channels enabled.
// - Three independent pairs, each own source.
// - Port B lines two/three/four drive pairs.
// - Timer channels zero/two/three drive pairs.
// - ADC slots zero/one/two drive pairs.
// - Over high limit deactivates, under low activates.
`timescale 1ns/10ps
`default_nettype none

module pps_top #(
  parameter int unsigned SYNC_WIDTH = 3
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [5:0] gen_pwm,
  input  wire logic [5:0] sw_ctrl_mode,
  input  wire logic [5:0] sw_ctrl_bit,
  input  wire logic [1:0] pair_sel_01,
  input  wire logic [1:0] pair_sel_23,
  input  wire logic [1:0] pair_sel_45,
  input  wire logic       port_b_line_two_in,
  input  wire logic       port_b_line_three_in,
  input  wire logic       port_b_line_four_in,
  input  wire logic       timer_channel_zero_out,
  input  wire logic       timer_channel_one_out,
  input  wire logic       timer_channel_two_out,
  input  wire logic       timer_channel_three_out,
  input  wire logic [2:0] adc_over_high,
  input  wire logic [2:0] adc_under_low,
  output var  logic [5:0] pwm_out,
  output var  logic [2:0] pair_alt_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Alternate source allowed when both channels are in software
  // control mode and both software control bits are set
  function automatic logic pair_alt_ok(
    input logic [1:0] mode,
    input logic [1:0] ctrl
  );
    pair_alt_ok = (&mode) & (&ctrl);
  endfunction : pair_alt_ok

  // Picks one pair's drive level from its selected source
  function automatic logic pick_source(
    input logic [1:0] sel,
    input logic       gpio_lvl,
    input logic       timer_lvl,
    input logic       adc_lvl,
    input logic       gen_lvl
  );
    logic lvl;
    lvl = gen_lvl;
    if (sel == pps_pkg::SEL_GPIO)
    begin
      lvl = gpio_lvl;
    end
    else if (sel == pps_pkg::SEL_TIMER)
    begin
      lvl = timer_lvl;
    end
    else if (sel == pps_pkg::SEL_ADC)
    begin
      lvl = adc_lvl;
    end
    pick_source = lvl;
  endfunction : pick_source

  ////////////////////////////////////////////////////////////////////////////
  // Port B lines are pins: two flops before use

  logic [SYNC_WIDTH-1:0] gpio_raw;
  logic [SYNC_WIDTH-1:0] gpio_sync;

  // Line two to pair 0/1, three to 2/3, four to 4/5
  assign gpio_raw = {port_b_line_four_in, port_b_line_three_in, port_b_line_two_in};

  pps_sync #(
    .WIDTH (SYNC_WIDTH)
  ) i_pps_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (gpio_raw),
    .sync_out (gpio_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pair source vectors

  logic [2:0] timer_src;
  logic [1:0] pair_sel [3];
  logic       unused_timer_one;

  // Timer zero to 0/1, two to 2/3, three to 4/5; channel one has no pair
  assign timer_src        = {timer_channel_three_out, timer_channel_two_out,
                             timer_channel_zero_out};
  assign unused_timer_one = timer_channel_one_out;

  // Each pair has its own select
  assign pair_sel[0] = pair_sel_01;
  assign pair_sel[1] = pair_sel_23;
  assign pair_sel[2] = pair_sel_45;

  ////////////////////////////////////////////////////////////////////////////
  // ADC limit level: held between limit events

  logic [2:0] adc_level_q;
  logic [2:0] adc_level_d;

  // Over high forces inactive, under low forces active, else hold;
  // slot k belongs to pair k
  always_comb
  begin
    adc_level_d = adc_level_q;
    for (int k = 0; k < 3; k++)
    begin
      if (adc_over_high[k])
      begin
        adc_level_d[k] = 1'b0;
      end
      else if (adc_under_low[k])
      begin
        adc_level_d[k] = 1'b1;
      end
    end
  end

  // Register the ADC levels
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adc_level_q <= pps_pkg::ADC_LEVEL_RST;
    end
    else
    begin
      adc_level_q <= adc_level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate-source flags: one per pair

  logic [2:0] alt_q;
  logic [2:0] alt_d;

  // Pair k leaves the generator only when enabled and not on select 3
  always_comb
  begin
    alt_d = pps_pkg::ALT_RST;
    for (int k = 0; k < 3; k++)
    begin
      alt_d[k] = pair_alt_ok(sw_ctrl_mode[2*k +: 2], sw_ctrl_bit[2*k +: 2]) &
                 (pair_sel[k] != pps_pkg::SEL_GEN);
    end
  end

  // Register the flags
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alt_q <= pps_pkg::ALT_RST;
    end
    else
    begin
      alt_q <= alt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: each pair from generator or its alternate source

  logic [5:0] pwm_q;
  logic [5:0] pwm_d;

  // Pair k drives output 2k with the source and 2k+1 with its complement;
  // the flag is used the same cycle so output and flag change together
  always_comb
  begin
    pwm_d = pps_pkg::PWM_RST;
    for (int k = 0; k < 3; k++)
    begin
      if (alt_d[k])
      begin
        pwm_d[2*k]     = pick_source(pair_sel[k], gpio_sync[k], timer_src[k],
                                     adc_level_q[k], gen_pwm[2*k]);
        pwm_d[2*k + 1] = ~pwm_d[2*k];
      end
      else
      begin
        pwm_d[2*k +: 2] = gen_pwm[2*k +: 2];
      end
    end
  end

  // Register the outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwm_q <= pps_pkg::PWM_RST;
    end
    else
    begin
      pwm_q <= pwm_d;
    end
  end

  // Top outputs come straight from the flops
  assign pwm_out         = pwm_q;
  assign pair_alt_active = alt_q;

endmodule : pps_top

`default_nettype wire

// file: testbench/pps_chk.sv
// Checker on pair 0 of the selector.
// Assumes it is bound into pps_top.
`timescale 1ns/10ps
`default_nettype none
module pps_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [5:0] gen_pwm,
  input wire logic [5:0] sw_ctrl_mode,
  input wire logic [5:0] sw_ctrl_bit,
  input wire logic [1:0] pair_sel_01,
  input wire logic       port_b_line_two_in,
  input wire logic       timer_channel_zero_out,
  input wire logic [2:0] adc_over_high,
  input wire logic [2:0] adc_under_low,
  input wire logic [5:0] pwm_out,
  input wire logic [2:0] pair_alt_active
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Pair 0 may take an alternate source
  wire a0 = &{sw_ctrl_mode[1:0], sw_ctrl_bit[1:0]} && pair_sel_01 != pps_pkg::SEL_GEN;
  property p_alt; 1 |=> pair_alt_active[0] == $past(a0); endproperty
  a_alt: assert property (p_alt) else $error("alt flag");
  property p_gen; !a0 |=> pwm_out[1:0] == $past(gen_pwm[1:0]); endproperty
  a_gen: assert property (p_gen) else $error("generator");
  property p_off; pair_sel_01 == pps_pkg::SEL_GEN |=> !pair_alt_active[0]; endproperty
  a_off: assert property (p_off) else $error("select 3");
  property p_tmr; a0 && pair_sel_01 == pps_pkg::SEL_TIMER
    |=> pwm_out[1:0] == ({2{$past(timer_channel_zero_out)}} ^ 2'h2); endproperty
  a_tmr: assert property (p_tmr) else $error("timer");
  property p_pin; a0 && pair_sel_01 == pps_pkg::SEL_GPIO
    |=> pwm_out[1:0] == ({2{$past(port_b_line_two_in, 3)}} ^ 2'h2); endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_lo; adc_under_low[0] && !adc_over_high[0] ##1 a0
    && pair_sel_01 == pps_pkg::SEL_ADC |=> pwm_out[1:0] == 2'h1; endproperty
  a_lo: assert property (p_lo) else $error("adc low");
  property p_hi; adc_over_high[0] ##1 a0
    && pair_sel_01 == pps_pkg::SEL_ADC |=> pwm_out[1:0] == 2'h2; endproperty
  a_hi: assert property (p_hi) else $error("adc high");
endmodule : pps_chk
bind pps_top pps_chk i_pps_chk (.*);
`default_nettype wire

// file: testbench/pps_far.sv
// Far-side sources: timer channels, ADC limit pulses, port B pins.
// Assumes levels may change at any falling edge and stay low in reset.
`timescale 1ns/10ps
`default_nettype none
module pps_far (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       slow,
  output var  logic [2:0] pin,
  output var  logic [3:0] tmr,
  output var  logic [2:0] over,
  output var  logic [2:0] under
);
  ////////////////////////////////////////
  // Levels change often, or rarely when slow; limit pulses are sparse
  initial {pin, tmr, over, under} = 13'h0000;
  always @(negedge sys_clk)
  begin
    if (!rst_b)
      {pin, tmr, over, under} <= 13'h0000;
    else
    begin
      if (!slow || $urandom_range(7) == 0)
        {pin, tmr} <= 7'($urandom);
      over  <= 3'($urandom & $urandom & $urandom);
      under <= 3'($urandom & $urandom);
    end
  end
endmodule : pps_far
`default_nettype wire

// file: testbench/test_pwm_pair_source_select.sv
// Self-checking bench for the pair source selector.
// Assumes pps_pkg, pps_top, pps_far and pps_chk are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("ERROR %0t got %h exp %h", $time, g, e); \
    end \
  end
module test_pwm_pair_source_select;
  logic sys_clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
  logic [5:0] gen = 6'h00, mode = 6'h00, cbit = 6'h00, sel = 6'h00, pwm_out;
  logic [2:0] act, pin, over, under, s1 = 3'h0, s2 = 3'h0, lv = 3'h0;
  logic [3:0] tmr;
  logic [8:0] exp_q[$], g;
  int failures = 0, comparisons = 0;
  ////////////////////////////////////////
  // Clock and instances
  always #2.5 sys_clk = ~sys_clk;
  pps_far i_pps_far (.sys_clk, .rst_b, .slow, .pin, .tmr, .over, .under);
  pps_top i_pps_top (.sys_clk, .rst_b, .gen_pwm(gen), .sw_ctrl_mode(mode), .sw_ctrl_bit(cbit),
    .pair_sel_01(sel[1:0]), .pair_sel_23(sel[3:2]), .pair_sel_45(sel[5:4]),
    .port_b_line_two_in(pin[0]), .port_b_line_three_in(pin[1]), .port_b_line_four_in(pin[2]),
    .timer_channel_zero_out(tmr[0]), .timer_channel_one_out(tmr[1]),
    .timer_channel_two_out(tmr[2]), .timer_channel_three_out(tmr[3]),
    .adc_over_high(over), .adc_under_low(under), .pwm_out, .pair_alt_active(act));
  // Expected outputs after the coming edge, then model state
  task automatic predict;
    logic [8:0] e;
    logic       src;
    e = {3'h0, gen};
    for (int k = 0; k < 3; k++)
    begin
      case (sel[2*k+:2])
        pps_pkg::SEL_GPIO:  src = s2[k];
        pps_pkg::SEL_TIMER: src = tmr[k + int'(k > 0)];
        default:            src = lv[k];
      endcase
      e[6+k] = &{mode[2*k+:2], cbit[2*k+:2]} && sel[2*k+:2] != pps_pkg::SEL_GEN;
      if (e[6+k])
        e[2*k+:2] = {!src, src};
    end
    exp_q.push_back(e);
    s2 = s1;
    s1 = pin;
    lv = (lv | under) & ~over;
  endtask : predict
  // Drive n falling edges, random controls or all pairs enabled with select vector s
  task automatic drive(input int n, input logic rnd, input logic [5:0] s);
    for (int i = 0; i < n; i++)
    begin
      @(negedge sys_clk);
      gen  <= 6'($urandom);
      mode <= rnd ? ~6'($urandom & $urandom) : 6'h3f;
      cbit <= rnd ? ~6'($urandom & $urandom) : 6'h3f;
      sel  <= rnd ? 6'($urandom) : s;
      #1 predict();
    end
  endtask : drive
  // Compare each result with the oldest note
  always @(posedge sys_clk)
  begin
    #1;
    if (exp_q.size() > 0)
    begin
      g = exp_q.pop_front();
      `CHK({act, pwm_out}, g)
    end
  end
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // Reset, random controls, select sweep, mixed selects
  initial
  begin
    void'($urandom(32'h8f78_c83a));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b <= 1'b1;
    drive(3000, 1'b1, 6'h00);
    $display("random controls done");
    slow = 1'b1;
    for (int s = 0; s < 4; s++)
      drive(200, 1'b0, {3{2'(s)}});
    drive(300, 1'b0, 6'h24);
    $display("select sweep done");
    repeat (3) @(posedge sys_clk);
    if (exp_q.size() != 0)
      failures++;
    end_sim();
  end
endmodule : test_pwm_pair_source_select
`default_nettype wire
